// ### hw/sct_pkg.sv
// Package for the synchronous DRAM command-timing block: command codes,
// latencies, reset values and the packed carriers shared by its modules.
// Assumes a single 100 MHz clock and a command bus driven by a controller.
package sct_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int DQ_W          = 32;
    localparam int MASK_W        = 4;
    localparam int ADDR_W        = 12;
    localparam int BANK_W        = 2;
    localparam int AP_BIT        = 10;
    localparam int BYTE_W        = 8;
    // CAS latency field of the mode word, placed by this block
    localparam int CL_LO         = 4;
    localparam int CL_HI         = 5;

    localparam int COLUMN_CMD_SPACING  = 1;
    localparam int CLKEN_ENTRY_LATENCY = 1;
    localparam int CLKEN_EXIT_LATENCY  = 1;
    localparam int WRITE_MASK_LATENCY  = 0;
    localparam int READ_MASK_FLOAT_LATENCY = 2;
    localparam int WRITE_CMD_TO_DATA_DELAY = 0;

    localparam logic [1:0] CAS_LAT_RESET = 2'h3;
    localparam logic [1:0] CAS_LAT_MIN   = 2'h1;

    // Command encodings as {select_n, row_n, col_n, wen_n}
    localparam logic [3:0] CMD_INHIBIT = 4'h8;
    localparam logic [3:0] CMD_NOP     = 4'h7;
    localparam logic [3:0] CMD_ACTIVE  = 4'h3;
    localparam logic [3:0] CMD_READ    = 4'h5;
    localparam logic [3:0] CMD_WRITE   = 4'h4;
    localparam logic [3:0] CMD_STOP    = 4'h6;
    localparam logic [3:0] CMD_PRECHG  = 4'h2;
    localparam logic [3:0] CMD_REFRESH = 4'h1;
    localparam logic [3:0] CMD_MODE    = 4'h0;

    localparam logic [3:0] NUM_BANKS_RESET = 4'h0;

    typedef struct packed {
        logic [3:0]        code;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
        logic [MASK_W-1:0] mask;
        logic [DQ_W-1:0]   wdata;
    } sct_cmd_t;

    typedef struct packed {
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
        logic              auto_pre;
        logic [MASK_W-1:0] mask;
        logic [DQ_W-1:0]   data;
    } sct_wr_t;

    typedef enum logic [1:0] {
        SCT_RUN,
        SCT_SUSPEND,
        SCT_SELF_REFRESH
    } sct_pwr_t;

endpackage : sct_pkg

// ### hw/sct_skid.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes both sides run on clk; ready on the input drops only when full.
`timescale 1ns/10ps
`default_nettype none
module sct_skid #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    logic [W-1:0] mem_q [2];
    logic         wp_q;
    logic         rp_q;
    logic [1:0]   cnt_q;
    wire          push = in_valid && in_ready;
    wire          pop  = out_valid && out_ready;

    assign in_ready  = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data  = mem_q[rp_q];

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wp_q  <= 1'b0;
            rp_q  <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                mem_q[wp_q] <= in_data;
                wp_q        <= ~wp_q;
            end
            if (pop) begin
                rp_q <= ~rp_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : sct_skid
`default_nettype wire

// ### hw/sct_core.sv
// Device-side command and data-mask timing of a four-bank synchronous DRAM.
// Assumes the controller keeps every spacing that binds it; commands come
// on one clock, already synchronous. Accepted writes leave through a buffer.
//
// Functional notes
// - Device accepts a READ, or a WRITE while the write buffer has room, on every clock cycle.
// - Device suspends one clock after clock enable sampled low; this block ignores commands other than REFRESH on that same edge.
// - Device resumes and accepts commands one clock after clock enable high.
// - Write mask gates same-edge input data; high mask blocks that byte.
// - Read mask high floats those data outputs two clocks later.
// - Precharge interrupting read: data driven CAS-latency clocks, then float.
// - Refresh code is auto refresh with clock enable high, self refresh low.
// - Address bit 10 high on READ or WRITE selects auto precharge.
`timescale 1ns/10ps
`default_nettype none
module sct_core #(
    parameter int DQ_WIDTH = sct_pkg::DQ_W
) (
    input  wire logic                          clk,
    input  wire logic                          nrst,
    input  wire logic                          clken,
    input  wire sct_pkg::sct_cmd_t             cmd,
    input  wire logic [sct_pkg::DQ_W-1:0]      rd_data,
    output logic [sct_pkg::DQ_W-1:0]           dq_out,
    output logic [sct_pkg::MASK_W-1:0]         dq_oe,
    output logic                               wr_valid,
    input  wire logic                          wr_ready,
    output sct_pkg::sct_wr_t                   wr_word,
    output logic                               wr_stall,
    output logic                               self_refresh,
    output logic                               suspended,
    output logic                               refresh_pulse,
    output logic                               mode_loaded,
    output logic [sct_pkg::BANK_W+1:0]         open_banks,
    output logic [1:0]                         cas_lat
);
    import sct_pkg::*;

    // Expands one mask bit per byte into a keep mask over the data word
    function automatic logic [DQ_W-1:0] lane_mask(input logic [MASK_W-1:0] m);
        logic [DQ_W-1:0] r;
        r = '0;
        for (int i = 0; i < MASK_W; i++) begin
            r[i*BYTE_W +: BYTE_W] = {BYTE_W{~m[i]}};
        end
        return r;
    endfunction : lane_mask

    sct_pwr_t        pwr_q;
    sct_pwr_t        pwr_d;
    logic            clken_q;
    logic [3:0]      bank_open_q;
    logic [1:0]      cl_q;
    logic            mode_q;
    logic            rd_act_q;
    logic [1:0]      float_cnt_q;
    logic [MASK_W-1:0] rmask_p1_q;
    logic [MASK_W-1:0] rmask_p2_q;
    logic [2:0]      rd_pipe_q;
    logic [DQ_W-1:0] dq_q;
    logic [MASK_W-1:0] oe_q;

    // Commands are only honoured while the device is running
    wire running   = (pwr_q == SCT_RUN);
    wire sel       = running && clken && (cmd.code != CMD_INHIBIT);
    wire is_read   = sel && (cmd.code == CMD_READ);
    wire is_write  = sel && (cmd.code == CMD_WRITE);
    wire is_act    = sel && (cmd.code == CMD_ACTIVE);
    wire is_pre    = sel && (cmd.code == CMD_PRECHG);
    wire is_mode   = sel && (cmd.code == CMD_MODE);
    wire is_stop   = sel && (cmd.code == CMD_STOP);
    wire mode_ok   = is_mode && (bank_open_q == NUM_BANKS_RESET);
    // Refresh with clock enable low is self-refresh entry
    wire is_ref    = running && clken_q && (cmd.code == CMD_REFRESH) && clken;
    wire is_sref   = running && clken_q && (cmd.code == CMD_REFRESH) && !clken;
    wire auto_pre  = cmd.addr[AP_BIT];
    wire pre_all   = cmd.addr[AP_BIT];
    wire [1:0] cl_field = cmd.addr[CL_HI:CL_LO];
    wire [1:0] cl_new   = (cl_field < CAS_LAT_MIN) ? CAS_LAT_MIN : cl_field;

    wire in_ready;
    sct_wr_t wr_in;
    assign wr_in.bank     = cmd.bank;
    assign wr_in.addr     = cmd.addr;
    assign wr_in.auto_pre = auto_pre;
    assign wr_in.mask     = cmd.mask;
    assign wr_in.data     = cmd.wdata & lane_mask(cmd.mask);

    // Data taken on the WRITE edge itself, one word per cycle
    sct_skid #(.W($bits(sct_wr_t))) u_buf (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (is_write),
        .in_ready  (in_ready),
        .in_data   (wr_in),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  (wr_word)
    );
    // A WRITE met by a full buffer is dropped; the stall flag lets the controller hold off
    assign wr_stall = !in_ready;

    // Clock enable low suspends after one clock; high resumes after one
    always_comb begin
        pwr_d = pwr_q;
        case (pwr_q)
            SCT_RUN: begin
                if (is_sref) begin
                    pwr_d = SCT_SELF_REFRESH;
                end else if (!clken) begin
                    pwr_d = SCT_SUSPEND;
                end
            end
            SCT_SUSPEND: begin
                if (clken) begin
                    pwr_d = SCT_RUN;
                end
            end
            SCT_SELF_REFRESH: begin
                if (clken) begin
                    pwr_d = SCT_RUN;
                end
            end
            default: begin
                pwr_d = SCT_RUN;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pwr_q   <= SCT_RUN;
            clken_q <= 1'b0;
        end else begin
            pwr_q   <= pwr_d;
            clken_q <= clken;
        end
    end

    // Bank state and mode register; mode load ignored unless all idle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            bank_open_q <= NUM_BANKS_RESET;
            cl_q        <= CAS_LAT_RESET;
            mode_q      <= 1'b0;
        end else begin
            if (is_act) begin
                bank_open_q[cmd.bank] <= 1'b1;
            end
            if (is_pre) begin
                if (pre_all) begin
                    bank_open_q <= NUM_BANKS_RESET;
                end else begin
                    bank_open_q[cmd.bank] <= 1'b0;
                end
            end
            if ((is_read || is_write) && auto_pre) begin
                bank_open_q[cmd.bank] <= 1'b0;
            end
            if (mode_ok) begin
                cl_q   <= cl_new;
                mode_q <= 1'b1;
            end
        end
    end

    // Output enable is registered, so it must drop on the edge that ends the float count
    wire last_float = (float_cnt_q == 2'h1);

    // Read path: mask sampled now floats the lane two clocks later
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rmask_p1_q  <= '1;
            rmask_p2_q  <= '1;
            rd_pipe_q   <= 3'h0;
            rd_act_q    <= 1'b0;
            float_cnt_q <= 2'h0;
            dq_q        <= '0;
            oe_q        <= '0;
        end else begin
            rmask_p1_q <= cmd.mask;
            rmask_p2_q <= rmask_p1_q;
            rd_pipe_q  <= {rd_pipe_q[1:0], is_read};
            if (rd_pipe_q[cl_q - 2'h1]) begin
                rd_act_q <= 1'b1;
            end
            // Precharge during a read keeps data for CAS-latency clocks
            if (is_pre && rd_act_q) begin
                float_cnt_q <= cl_q;
            end else if (float_cnt_q != 2'h0) begin
                float_cnt_q <= float_cnt_q - 2'h1;
                if (float_cnt_q == 2'h1) begin
                    rd_act_q <= 1'b0;
                end
            end else if (is_stop || is_write) begin
                rd_act_q <= 1'b0;
            end
            dq_q <= rd_data;
            oe_q <= (rd_act_q && !suspended && !last_float) ? ~rmask_p2_q : '0;
        end
    end

    assign dq_out        = dq_q;
    assign dq_oe         = oe_q;
    assign suspended     = (pwr_q == SCT_SUSPEND);
    assign self_refresh  = (pwr_q == SCT_SELF_REFRESH);
    assign refresh_pulse = is_ref;
    assign mode_loaded   = mode_q;
    assign open_banks    = bank_open_q;
    assign cas_lat       = cl_q;
endmodule : sct_core
`default_nettype wire

// ### testbench/sct_assertions.sv
// Concurrent checks on the ports of the command-timing core.
// Bound to sct_core from the bench; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module sct_chk (
    input wire logic                       clk,
    input wire logic                       nrst,
    input wire logic                       clken,
    input wire sct_pkg::sct_cmd_t          cmd,
    input wire logic [sct_pkg::MASK_W-1:0] dq_oe,
    input wire logic                       wr_valid,
    input wire sct_pkg::sct_wr_t           wr_word,
    input wire logic                       wr_stall,
    input wire logic                       self_refresh,
    input wire logic                       suspended,
    input wire logic                       refresh_pulse,
    input wire logic [sct_pkg::BANK_W+1:0] open_banks,
    input wire logic [1:0]                 cas_lat
);
    import sct_pkg::*;
    logic            run;
    logic            take;
    logic            wr_in;
    logic            ap;
    logic [1:0]      cl_in;
    logic [1:0]      cl_exp;
    logic [DQ_W-1:0] kept;
    assign run   = !suspended && !self_refresh;
    assign take  = run && clken;
    assign wr_in = take && cmd.code == CMD_WRITE && !wr_valid;
    assign ap    = cmd.addr[AP_BIT];
    assign cl_in = cmd.addr[CL_HI:CL_LO];
    assign cl_exp = (cl_in == 2'h0) ? CAS_LAT_MIN : cl_in;
    assign kept  = cmd.wdata & {{8{!cmd.mask[3]}}, {8{!cmd.mask[2]}},
                                {8{!cmd.mask[1]}}, {8{!cmd.mask[0]}}};
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_SUSPEND_IN: assert property (run && !clken && cmd.code != CMD_REFRESH |=> suspended)
        else $error("suspend not entered");
    AST_SUSPEND_OUT: assert property (suspended && clken |=> !suspended)
        else $error("suspend not left");
    AST_SELF_REFRESH: assert property (run && $past(nrst) && $past(clken) && !clken
        && cmd.code == CMD_REFRESH |=> self_refresh)
        else $error("self refresh not entered");
    AST_AUTO_REFRESH: assert property (take && $past(nrst) && $past(clken)
        && cmd.code == CMD_REFRESH |-> refresh_pulse)
        else $error("auto refresh not decoded");
    AST_NO_PULSE: assert property (cmd.code != CMD_REFRESH |-> !refresh_pulse)
        else $error("stray refresh pulse");
    AST_WRITE_MASK: assert property (wr_in |=> wr_valid && wr_word.data == $past(kept))
        else $error("write mask wrong");
    AST_AUTO_PRE: assert property (wr_in |=> wr_word.auto_pre == $past(ap))
        else $error("auto precharge flag wrong");
    AST_NEXT_WRITE: assert property (wr_in |=> !wr_stall)
        else $error("second write refused");
    AST_READ_FLOAT: assert property ((take && cmd.mask == 4'hF) [*4] |-> dq_oe == 4'h0)
        else $error("masked outputs not floating");
    AST_MODE_REFUSED: assert property (take && cmd.code == CMD_MODE && open_banks != 4'h0
        |=> $stable(cas_lat))
        else $error("mode load with open bank");
    AST_MODE_TAKEN: assert property (take && cmd.code == CMD_MODE && open_banks == 4'h0
        |=> cas_lat == $past(cl_exp))
        else $error("mode load not applied");
endmodule : sct_chk
`default_nettype wire

// ### testbench/sct_ctrl_model.sv
// Behavioural memory controller: commands, write data and clock enable.
// Assumes one caller at a time; each command launches on a rising edge.
`timescale 1ns/10ps
`default_nettype none
module sct_ctrl_model #(
    parameter int PAUSE_CYC = 10000
) (
    input  wire logic             clk,
    output var sct_pkg::sct_cmd_t cmd,
    output var logic              clken
);
    import sct_pkg::*;
    // Gaps rounded up to whole clocks; the device cannot police them
    localparam int XSR_CYC = (70 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RFC_CYC = 7;
    initial begin
        cmd      = '0;
        cmd.code = CMD_NOP;
        clken    = 1'h1;
    end
    task automatic issue(input logic [3:0] c, input logic [11:0] a, input logic [3:0] m,
                         input logic [31:0] d, input logic ce, input int gap);
        @(posedge clk);
        cmd   <= '{code: c, bank: 2'h1, addr: a, mask: m, wdata: d};
        clken <= ce;
        repeat (gap) begin
            @(posedge clk);
            cmd.code <= CMD_NOP;
        end
    endtask : issue
    task automatic power_up();
        repeat (PAUSE_CYC) @(posedge clk);
        repeat (2) issue(CMD_REFRESH, 12'h0, 4'hF, 32'h0, 1'h1, RFC_CYC);
    endtask : power_up
endmodule : sct_ctrl_model
`default_nettype wire

// ### testbench/sct_core_bench.sv
// Self-checking bench for the command-timing core with a controller model.
// Assumes model tasks return at the edge that launched the last command.
`timescale 1ns/10ps
`default_nettype none
module sct_core_bench;
    import sct_pkg::*;
    logic            clk, nrst, clken, wr_ready, wr_valid, wr_stall;
    logic            self_refresh, suspended, refresh_pulse, mode_loaded;
    logic [DQ_W-1:0] rd_data, dq_out;
    logic [3:0]      dq_oe, open_banks;
    logic [1:0]      cas_lat;
    sct_cmd_t        cmd;
    sct_wr_t         wr_word;
    int              errors, cmp_count;
    sct_core sct_core_inst (.clk(clk), .nrst(nrst), .clken(clken), .cmd(cmd), .rd_data(rd_data),
        .dq_out(dq_out), .dq_oe(dq_oe), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_word(wr_word),
        .wr_stall(wr_stall), .self_refresh(self_refresh), .suspended(suspended),
        .refresh_pulse(refresh_pulse), .mode_loaded(mode_loaded), .open_banks(open_banks),
        .cas_lat(cas_lat));
    sct_ctrl_model sct_ctrl_model_inst (.clk(clk), .cmd(cmd), .clken(clken));
    always #5 clk = ~clk;
    always @(posedge clk) rd_data <= rd_data + 32'h01010101;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict
    task automatic op(input logic [3:0] c, input logic [11:0] a, input logic [3:0] m,
                      input logic [31:0] d, input logic ce, input int gap);
        sct_ctrl_model_inst.issue(c, a, m, d, ce, gap);
    endtask : op
    task automatic t_self_refresh();
        op(CMD_REFRESH, 12'h0, 4'hF, 32'h0, 1'h1, 0);
        #1 check("refresh_pulse", 32'(refresh_pulse), 32'h1);
        op(CMD_NOP, 12'h0, 4'hF, 32'h0, 1'h1, 6);
        op(CMD_REFRESH, 12'h0, 4'hF, 32'h0, 1'h0, 0);
        op(CMD_NOP, 12'h0, 4'hF, 32'h0, 1'h0, 0);
        #1 check("self_refresh", 32'(self_refresh), 32'h1);
        op(CMD_NOP, 12'h0, 4'hF, 32'h0, 1'h1, 0);
        op(CMD_NOP, 12'h0, 4'hF, 32'h0, 1'h1, 0);
        #1 check("self_refresh", 32'(self_refresh), 32'h0);
        op(CMD_NOP, 12'h0, 4'hF, 32'h0, 1'h1, sct_ctrl_model_inst.XSR_CYC);
    endtask : t_self_refresh
    task automatic t_suspend();
        // Receiver stalls so a wrongly taken write would stay visible
        wr_ready <= 1'h0;
        op(CMD_NOP, 12'h0, 4'hF, 32'h0, 1'h0, 0);
        op(CMD_WRITE, 12'h0, 4'h0, 32'h12345678, 1'h0, 0);
        #1 check("suspended", 32'(suspended), 32'h1);
        op(CMD_NOP, 12'h0, 4'hF, 32'h0, 1'h1, 0);
        op(CMD_NOP, 12'h0, 4'hF, 32'h0, 1'h1, 0);
        #1 check("suspended", 32'(suspended), 32'h0);
        check("wr_valid", 32'(wr_valid), 32'h0);
    endtask : t_suspend
    task automatic t_write_buffer();
        op(CMD_ACTIVE, 12'h0, 4'hF, 32'h0, 1'h1, 2);
        op(CMD_WRITE, 12'h010, 4'h5, 32'h11223344, 1'h1, 0);
        op(CMD_WRITE, 12'h400, 4'hA, 32'hAABBCCDD, 1'h1, 0);
        op(CMD_WRITE, 12'h0, 4'h0, 32'hFFFFFFFF, 1'h1, 0);
        #1 check("wr_stall", 32'(wr_stall), 32'h1);
        op(CMD_STOP, 12'h0, 4'hF, 32'h0, 1'h1, 0);
        wr_ready <= 1'h1;
        #1 check("wr_word.data", wr_word.data, 32'h11003300);
        check("wr_word.auto_pre", 32'(wr_word.auto_pre), 32'h0);
        @(posedge clk);
        #1 check("wr_word.data", wr_word.data, 32'h00BB00DD);
        check("wr_word.auto_pre", 32'(wr_word.auto_pre), 32'h1);
        @(posedge clk);
        #1 check("wr_valid", 32'(wr_valid), 32'h0);
    endtask : t_write_buffer
    task automatic t_mode_read();
        int k;
        int n;
        op(CMD_PRECHG, 12'h400, 4'hF, 32'h0, 1'h1, 5);
        op(CMD_MODE, 12'h020, 4'hF, 32'h0, 1'h1, 2);
        #1 check("cas_lat", 32'(cas_lat), 32'h2);
        check("mode_loaded", 32'(mode_loaded), 32'h1);
        op(CMD_ACTIVE, 12'h0A5, 4'hF, 32'h0, 1'h1, 3);
        op(CMD_MODE, 12'h030, 4'hF, 32'h0, 1'h1, 2);
        #1 check("cas_lat", 32'(cas_lat), 32'h2);
        check("open_banks", 32'(open_banks), 32'h2);
        op(CMD_READ, 12'h0, 4'h0, 32'h0, 1'h1, 0);
        k = 0;
        while (dq_oe !== 4'hF && k < 8) begin
            @(posedge clk);
            #1 k++;
        end
        check("dq_oe", 32'(dq_oe), 32'hF);
        check("dq_out", dq_out, rd_data - 32'h01010101);
        if (dq_oe !== 4'hF) give_verdict();
        op(CMD_PRECHG, 12'h0, 4'h0, 32'h0, 1'h1, 0);
        n = 0;
        repeat (8) begin
            op(CMD_NOP, 12'h0, 4'h0, 32'h0, 1'h1, 0);
            #1 n += int'(dq_oe !== 4'h0);
        end
        check("dq_oe cycles", 32'(n), 32'h2);
    endtask : t_mode_read
    initial begin
        clk       = 1'h0;
        nrst      = 1'h0;
        wr_ready  = 1'h1;
        rd_data   = 32'h0;
        errors    = 0;
        cmp_count = 0;
        repeat (10) @(posedge clk);
        nrst <= 1'h1;
        sct_ctrl_model_inst.power_up();
        t_self_refresh();
        t_suspend();
        t_write_buffer();
        t_mode_read();
        give_verdict();
    end
endmodule : sct_core_bench
bind sct_core sct_chk sct_chk_inst (.clk(clk), .nrst(nrst), .clken(clken), .cmd(cmd),
    .dq_oe(dq_oe), .wr_valid(wr_valid), .wr_word(wr_word), .wr_stall(wr_stall),
    .self_refresh(self_refresh), .suspended(suspended), .refresh_pulse(refresh_pulse),
    .open_banks(open_banks), .cas_lat(cas_lat));
`default_nettype wire
